//--- hdl/tmon_top.sv
// Serial slave, limit comparators and alarm pins of the thermal monitor.
// Assumes an open-drain bus outside; output enables high mean pulling low.
module tmon_top (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       serial_clock_line,
  input  wire logic       serial_data_line_in,
  output logic            serial_data_line_out,
  output logic            serial_data_line_oe,
  input  wire logic       window_alarm_in,
  output logic            window_alarm_out,
  output logic            window_alarm_oe,
  output logic            critical_shutdown_n,
  output logic            critical_shutdown_oe,
  input  wire logic [7:0] local_sample,
  input  wire logic [7:0] remote_sample,
  input  wire logic       sample_valid,
  output logic            conv_start,
  output logic            conv_busy
);
  import tmon_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_SEND, ST_IGNORE} tmon_state_type;

  logic           scl;
  logic           sda;
  logic           scl_q;
  logic           sda_q;
  tmon_state_type state;
  logic [3:0]     bit_cnt;
  logic [7:0]     shift;
  logic           ack_phase;
  logic           is_read;
  logic [7:0]     cmd;
  logic           cmd_valid;
  logic [24:0]    low_cnt;
  logic           timeout;
  logic [7:0]     local_temp;
  logic [7:0]     remote_temp;
  logic [7:0]     loc_high;
  logic [7:0]     loc_low;
  logic [7:0]     rem_high;
  logic [7:0]     rem_low;
  logic [7:0]     crit_limit;
  logic [7:0]     cfg;
  logic [3:0]     rate;
  logic           pol_high;
  logic           addr_sel;
  logic [2:0]     strap_wait;
  logic           strap_level;
  logic [7:0]     rd_byte;
  logic [7:0]     status;
  logic           wr_pulse;
  logic [7:0]     wr_data;
  logic           stop_seen;
  logic [27:0]    conv_cnt;
  logic           window_hit;
  logic           crit_hit;

  tmon_sync u_scl (.mclk(mclk), .sys_rst(sys_rst), .pin(serial_clock_line), .level(scl));
  tmon_sync u_sda (.mclk(mclk), .sys_rst(sys_rst), .pin(serial_data_line_in), .level(sda));
  tmon_sync u_strap (.mclk(mclk), .sys_rst(sys_rst), .pin(window_alarm_in), .level(strap_level));

  function automatic logic out_of_window(input logic [7:0] t, input logic [7:0] hi, input logic [7:0] lo);
    return ($signed(t) > $signed(hi)) || ($signed(t) < $signed(lo));
  endfunction

  wire start_cond = scl && scl_q && sda_q && !sda;
  wire stop_cond  = scl && scl_q && !sda_q && sda;
  wire scl_rise   = scl && !scl_q;
  wire scl_fall   = !scl && scl_q;
  wire [6:0] my_addr = addr_sel ? ADDR_B : ADDR_A;  // R04 R08
  // The strap is taken only once the pin synchroniser has filled with real pin levels.
  wire       strap_done = (strap_wait == 3'd7);

  // =====================================
  // Edge history and bus timeout
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      low_cnt <= '0;
      timeout <= 1'b0;
    end
    else
    begin
      scl_q   <= scl;
      sda_q   <= sda;
      timeout <= 1'b0;
      if (scl)
      begin
        low_cnt <= '0;
      end
      else if (low_cnt == 25'(TIMEOUT_CYC - 1))
      begin
        timeout <= 1'b1;  // R05
        low_cnt <= '0;
      end
      else
      begin
        low_cnt <= low_cnt + 25'd1;
      end
    end
  end

  // =====================================
  // Serial slave
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state                <= ST_IDLE;
      bit_cnt              <= '0;
      shift                <= '0;
      ack_phase            <= 1'b0;
      is_read              <= 1'b0;
      cmd                  <= '0;
      cmd_valid            <= 1'b0;
      serial_data_line_oe  <= 1'b0;
      serial_data_line_out <= 1'b0;
      wr_pulse             <= 1'b0;
      wr_data              <= '0;
      stop_seen            <= 1'b0;
    end
    else
    begin
      wr_pulse             <= 1'b0;
      stop_seen            <= 1'b0;
      serial_data_line_out <= 1'b0;
      if (timeout)
      begin
        state               <= ST_IDLE;  // R15
        serial_data_line_oe <= 1'b0;
        cmd_valid           <= 1'b0;
      end
      else if (start_cond)
      begin
        state               <= ST_ADDR;
        bit_cnt             <= '0;
        ack_phase           <= 1'b0;
        serial_data_line_oe <= 1'b0;
      end
      else if (stop_cond)
      begin
        state               <= ST_IDLE;
        serial_data_line_oe <= 1'b0;
        stop_seen           <= 1'b1;  // R13
      end
      else if (scl_rise && !ack_phase && state != ST_SEND && state != ST_IDLE)
      begin
        shift   <= {shift[6:0], sda};
        bit_cnt <= bit_cnt + 4'd1;
      end
      else if (scl_rise && state == ST_SEND && ack_phase)
      begin
        state <= sda ? ST_IGNORE : ST_SEND;  // R14
      end
      else if (scl_fall)
      begin
        if (ack_phase)
        begin
          ack_phase <= 1'b0;
          bit_cnt   <= '0;
          if (state == ST_SEND)
          begin
            serial_data_line_oe <= !rd_byte[7];
            shift               <= {rd_byte[6:0], 1'b0};
            bit_cnt             <= 4'd1;
          end
          else
          begin
            serial_data_line_oe <= 1'b0;
          end
        end
        else if (state == ST_SEND)
        begin
          if (bit_cnt == 4'd8)
          begin
            serial_data_line_oe <= 1'b0;
            ack_phase           <= 1'b1;
          end
          else
          begin
            serial_data_line_oe <= !shift[7];
            shift               <= {shift[6:0], 1'b0};
            bit_cnt             <= bit_cnt + 4'd1;
          end
        end
        else if (bit_cnt == 4'd8)
        begin
          unique case (state)
            ST_ADDR:
            begin
              if (shift[7:1] == my_addr)
              begin
                serial_data_line_oe <= 1'b1;  // R10
                ack_phase           <= 1'b1;
                is_read             <= shift[0];
                state               <= shift[0] ? ST_SEND : ST_CMD;  // R09
              end
              else
              begin
                state <= ST_IGNORE;  // R16
              end
            end
            ST_CMD:
            begin
              cmd                 <= shift;  // R11
              cmd_valid           <= 1'b1;
              serial_data_line_oe <= 1'b1;
              ack_phase           <= 1'b1;
              state               <= ST_DATA;
            end
            ST_DATA:
            begin
              wr_data             <= shift;
              wr_pulse            <= 1'b1;  // R12
              serial_data_line_oe <= 1'b1;
              ack_phase           <= 1'b1;
              state               <= ST_IGNORE;
            end
            default:
            begin
              state <= ST_IGNORE;
            end
          endcase
        end
      end
    end
  end

  function automatic logic [7:0] read_value(input logic [7:0] idx);
    unique case (idx)
      IDX_LOCAL:    read_value = local_temp;
      IDX_REMOTE:   read_value = remote_temp;
      IDX_STATUS:   read_value = status;
      IDX_CFG_RD:   read_value = cfg;
      IDX_RATE_RD:  read_value = {4'h0, rate};
      IDX_LHI_RD:   read_value = loc_high;
      IDX_LLO_RD:   read_value = loc_low;
      IDX_RHI_RD:   read_value = rem_high;
      IDX_RLO_RD:   read_value = rem_low;
      IDX_CRIT:     read_value = crit_limit;
      IDX_POLARITY: read_value = {6'h00, pol_high, 1'b0};
      IDX_ADDR_SEL: read_value = {7'h00, addr_sel};
      default:      read_value = READ_NONE;
    endcase
  endfunction

  assign rd_byte = read_value(cmd);  // R11

  // =====================================
  // Register writes and address strap
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      loc_high   <= HIGH_RST;
      loc_low    <= LOW_RST;
      rem_high   <= HIGH_RST;
      rem_low    <= LOW_RST;
      crit_limit <= CRIT_RST;
      cfg        <= '0;
      rate       <= RATE_RST;
      pol_high   <= 1'b0;  // R06
      addr_sel   <= 1'b0;
      strap_wait <= '0;
    end
    else
    begin
      if (!strap_done)
      begin
        // The alarm pin is released during reset, so the strap level is valid here.
        if (strap_wait == 3'd6)
        begin
          addr_sel <= strap_level;  // R07
        end
        strap_wait <= strap_wait + 3'd1;
      end
      else if (wr_pulse && cmd_valid)
      begin
        unique case (cmd)
          IDX_CFG_WR:   cfg <= {wr_data[7:6], 1'b0, wr_data[4], 4'h0};
          IDX_RATE_WR:  rate <= wr_data[3:0];
          IDX_LHI_WR:   loc_high <= wr_data;
          IDX_LLO_WR:   loc_low <= wr_data;
          IDX_RHI_WR:   rem_high <= wr_data;
          IDX_RLO_WR:   rem_low <= wr_data;
          IDX_CRIT:     crit_limit <= wr_data;
          IDX_POLARITY: pol_high <= wr_data[POL_BIT];  // R06
          IDX_ADDR_SEL: addr_sel <= wr_data[0];  // R07
          default:      ;
        endcase
      end
    end
  end

  // =====================================
  // Conversion timing and results
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      conv_cnt    <= '0;
      conv_busy   <= 1'b0;
      conv_start  <= 1'b0;
      local_temp  <= '0;
      remote_temp <= '0;
    end
    else
    begin
      conv_start <= 1'b0;
      if (stop_seen && !cfg[CFG_STOP])
      begin
        conv_busy  <= 1'b1;
        conv_start <= 1'b1;
        conv_cnt   <= 28'(CONV_CYC);  // R13
      end
      else if (conv_busy)
      begin
        conv_cnt <= conv_cnt - 28'd1;
        if (conv_cnt == 28'd1)
        begin
          conv_busy <= 1'b0;
        end
      end
      if (sample_valid)
      begin
        local_temp  <= local_sample;  // R01
        remote_temp <= remote_sample;  // R01
      end
    end
  end

  assign window_hit = out_of_window(local_temp, loc_high, loc_low)
                    || out_of_window(remote_temp, rem_high, rem_low);  // R02
  assign crit_hit   = ($signed(local_temp) > $signed(crit_limit))
                    || ($signed(remote_temp) > $signed(crit_limit));  // R03
  assign status     = {conv_busy, 7'h00};

  // =====================================
  // Alarm pins
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      window_alarm_out     <= 1'b0;
      window_alarm_oe      <= 1'b0;
      critical_shutdown_n  <= 1'b1;
      critical_shutdown_oe <= 1'b0;
    end
    else if (strap_done)
    begin
      // Alarms drive low when asserted in low polarity, and low when idle in high polarity.
      window_alarm_oe      <= (window_hit && !cfg[CFG_ALERT_MASK]) ^ pol_high;  // R02 R06
      critical_shutdown_oe <= (crit_hit && !cfg[CFG_CRIT_MASK]) ^ pol_high;  // R03 R06
      critical_shutdown_n  <= !((crit_hit && !cfg[CFG_CRIT_MASK]) ^ pol_high);
    end
  end
endmodule // tmon_top

//--- hdl/tmon_pkg.sv
// Constants for the two-channel thermal monitor serial slave.
// Assumes one 20 MHz clock and that the converter delivers signed 8-bit results.
// Overview of operation
// R01 - Keep separate local and remote temperature results.
// R02 - Window alarm when outside high/low limits.
// R03 - Critical alarm when above critical limit.
// R04 - Variants answer 8-bit address 0x90 or 0x94.
// R05 - Clock low past timeout resets interface.
// R06 - Alarms active low; index 0x31 bit1 inverts.
// R07 - Address strap sampled on alarm pin; index 0x42.
// R08 - Slave addresses 1001000 and 1001010.
// R09 - Only write-byte and read-byte supported.
// R10 - Write: address, command, data, each acknowledged.
// R11 - Command byte selects the internal register.
// R12 - Write data stored into selected register.
// R13 - Conversion after stop completes within 95-156 ms.
// R14 - Read: command, repeated start, one byte, nack.
// R15 - Timeout releases data, drops partial transaction.
// R16 - Foreign address is not acknowledged.
package tmon_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned TIMEOUT_MS      = 25;
  localparam int unsigned TIMEOUT_CYC     = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int unsigned CONV_MS         = 125;
  localparam int unsigned CONV_CYC        = CLK_HZ / 1000 * CONV_MS;
  localparam logic [6:0] ADDR_A           = 7'h48;
  localparam logic [6:0] ADDR_B           = 7'h4a;
  localparam logic [7:0] IDX_LOCAL        = 8'h00;
  localparam logic [7:0] IDX_REMOTE       = 8'h01;
  localparam logic [7:0] IDX_STATUS       = 8'h02;
  localparam logic [7:0] IDX_CFG_RD       = 8'h03;
  localparam logic [7:0] IDX_RATE_RD      = 8'h04;
  localparam logic [7:0] IDX_LHI_RD       = 8'h05;
  localparam logic [7:0] IDX_LLO_RD       = 8'h06;
  localparam logic [7:0] IDX_RHI_RD       = 8'h07;
  localparam logic [7:0] IDX_RLO_RD       = 8'h08;
  localparam logic [7:0] IDX_CFG_WR       = 8'h09;
  localparam logic [7:0] IDX_RATE_WR      = 8'h0a;
  localparam logic [7:0] IDX_LHI_WR       = 8'h0b;
  localparam logic [7:0] IDX_LLO_WR       = 8'h0c;
  localparam logic [7:0] IDX_RHI_WR       = 8'h0d;
  localparam logic [7:0] IDX_RLO_WR       = 8'h0e;
  localparam logic [7:0] IDX_CRIT         = 8'h20;
  localparam logic [7:0] IDX_POLARITY     = 8'h31;
  localparam logic [7:0] IDX_ADDR_SEL     = 8'h42;
  localparam int unsigned POL_BIT         = 1;
  localparam int unsigned CFG_ALERT_MASK  = 7;
  localparam int unsigned CFG_STOP        = 6;
  localparam int unsigned CFG_CRIT_MASK   = 4;
  localparam logic [7:0] HIGH_RST         = 8'h50;
  localparam logic [7:0] LOW_RST          = 8'h00;
  localparam logic [7:0] CRIT_RST         = 8'h64;
  localparam logic [3:0] RATE_RST         = 4'h8;
  localparam logic [7:0] READ_NONE        = 8'hff;
endpackage : tmon_pkg

//--- hdl/tmon_sync.sv
// Three-flop synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to mclk.
module tmon_sync (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic pin,
  output logic      level
);
  logic [2:0] stage;

  // =====================================
  // Sampling
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage <= 3'b111;
      level <= 1'b1;
    end
    else
    begin
      stage <= {stage[1:0], pin};
      // Only the second and third stages are compared; the first may be metastable.
      if (stage[1] == stage[2])
      begin
        level <= stage[2];
      end
    end
  end
endmodule // tmon_sync

//--- testbench/tmon_host.sv
// Bus master model: drives the serial clock and pulls the data line low.
// Assumes pull-ups on the board; one bit takes 8 mclk cycles (400 ns).
module tmon_host (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Bit and frame primitives
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Data moves mid low phase, so the slave sees it settled long before the clock rises.
  // The low phase is the longer one: the slave lets go of its bit about five cycles after the fall.
  task automatic bit_io(input logic b, output logic r);
    wt(3);
    sda_pull <= !b;
    wt(2);
    scl <= 1'b1;
    wt(3);
    r = sda;
    scl <= 1'b0;
  endtask
  // Serves as first start and as repeated start.
  // The clock rises late so that the slave's released ack is not seen as a stop.
  task automatic start();
    wt(2);
    sda_pull <= 1'b0;
    wt(4);
    scl <= 1'b1;
    wt(4);
    sda_pull <= 1'b1;
    wt(4);
    scl <= 1'b0;
  endtask
  // The clock is left high afterwards: it stands still between frames.
  task automatic stop();
    wt(2);
    sda_pull <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_pull <= 1'b0;
    wt(8);
  endtask
  task automatic tx(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rx(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(1'b1, r);
  endtask
  task automatic wr(input logic [7:0] a, c, d, output logic ok);
    logic k1, k2, k3;
    start();
    tx(a, k1);
    tx(c, k2);
    tx(d, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [7:0] a, c, output logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    start();
    tx(a, k1);
    tx(c, k2);
    start();
    tx(a | 8'h01, k3);
    rx(d);
    stop();
    ok = k1 & k2 & k3;
  endtask
endmodule // tmon_host

//--- testbench/tmon_top_asserts.sv
// Concurrent checks on the pins of the thermal monitor.
// Assumes it is bound to tmon_top and sees only its ports.
module tmon_top_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic serial_clock_line,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe,
  input wire logic window_alarm_out,
  input wire logic window_alarm_oe,
  input wire logic critical_shutdown_n,
  input wire logic critical_shutdown_oe,
  input wire logic conv_start,
  input wire logic conv_busy
);
  // ==========================================================
  // Pin and conversion checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_bus_idle;
    serial_clock_line [*8];
  endsequence
  sequence s_conv_run;
    conv_busy [*8];
  endsequence
  chk_sda_open_drain: assert property (serial_data_line_oe |-> !serial_data_line_out)
    else $error("data line driven high");
  chk_alarm_open_drain: assert property (window_alarm_oe |-> !window_alarm_out)
    else $error("window alarm driven high");
  chk_crit_mirror: assert property (critical_shutdown_oe |-> !critical_shutdown_n)
    else $error("critical level disagrees with enable");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  chk_busy_follows: assert property (conv_start |=> conv_busy)
    else $error("no busy after conversion start");
  chk_busy_hold: assert property ($rose(conv_busy) |-> s_conv_run)
    else $error("busy dropped early");
  chk_start_on_stop: assert property (conv_start |-> serial_clock_line && $past(serial_clock_line, 2))
    else $error("conversion started while clock low");
  chk_idle_release: assert property (s_bus_idle |-> !serial_data_line_oe)
    else $error("data line held while bus idle");
endmodule // tmon_top_asserts

//--- testbench/test_tmon_top.sv
// Self-checking bench for the thermal monitor serial slave and alarm pins.
// Assumes tmon_host as bus master and pull-ups on every open-drain line.
module test_tmon_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tmon_pkg::*;
  // ==========================================================
  // Wiring
  logic       mclk = 1'b0, sys_rst = 1'b1, strap_low = 1'b0, sample_valid = 1'b0, ok;
  logic [7:0] local_sample = 8'h00, remote_sample = 8'h00, rdata;
  wire        serial_clock_line, sda_pull, serial_data_line_out, serial_data_line_oe;
  wire        window_alarm_out, window_alarm_oe, critical_shutdown_n, critical_shutdown_oe;
  wire        conv_start, conv_busy;
  wire        serial_data_line_in = !(sda_pull | serial_data_line_oe);
  wire        window_alarm_in = strap_low ? 1'b0 : !window_alarm_oe;
  int         n_fail = 0, comparisons = 0, n_conv = 0;
  always #25 mclk = ~mclk;
  always @(posedge mclk) if (conv_start === 1'b1) n_conv++;
  tmon_top dut_u (.mclk, .sys_rst, .serial_clock_line, .serial_data_line_in, .serial_data_line_out,
    .serial_data_line_oe, .window_alarm_in, .window_alarm_out, .window_alarm_oe, .critical_shutdown_n,
    .critical_shutdown_oe, .local_sample, .remote_sample, .sample_valid, .conv_start, .conv_busy);
  tmon_host host_u (.mclk(mclk), .sda(serial_data_line_in), .scl(serial_clock_line), .sda_pull(sda_pull));
  // ==========================================================
  // Helpers
  task automatic chk8(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    strap_low <= s;
    sys_rst <= 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge mclk);
    strap_low <= 1'b0;
  endtask
  task automatic load(input logic [7:0] l, r);
    @(posedge mclk);
    local_sample <= l;
    remote_sample <= r;
    sample_valid <= 1'b1;
    @(posedge mclk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic acc(input logic [7:0] a, c, e, input logic k);
    host_u.rd(a, c, rdata, ok);
    chk8({7'h00, ok}, {7'h00, k});
    if (k) chk8(rdata, e);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_defaults();
    logic [7:0] idx [5] = '{IDX_LHI_RD, IDX_LLO_RD, IDX_RHI_RD, IDX_RLO_RD, 8'h77};
    logic [7:0] exp [5] = '{HIGH_RST, LOW_RST, HIGH_RST, LOW_RST, READ_NONE};
    chk8({5'h00, window_alarm_out, window_alarm_oe, critical_shutdown_oe}, 8'h00);
    for (int i = 0; i < 5; i++) acc(8'h94, idx[i], exp[i], 1'b1);
    $display("defaults done");
  endtask
  task automatic t_write();
    int c0 = n_conv;
    host_u.wr(8'h94, IDX_LHI_WR, 8'h3c, ok);
    chk8({7'h00, ok}, 8'h01);
    chk8(8'(n_conv - c0), 8'h01);
    chk8({7'h00, conv_busy}, 8'h01);
    acc(8'h94, IDX_LHI_RD, 8'h3c, 1'b1);
    $display("write done");
  endtask
  // Rows hit the local high, remote high and critical limits exactly at their boundary; only critical is also hit just past it.
  task automatic t_alarms();
    logic [7:0] lt [7] = '{8'h40, 8'h20, 8'h20, 8'h20, 8'h65, 8'h3c, 8'h20};
    logic [7:0] rt [7] = '{8'h20, 8'hf0, 8'h70, 8'h20, 8'h20, 8'h50, 8'h64};
    logic [1:0] ex [7] = '{2'b10, 2'b10, 2'b11, 2'b00, 2'b11, 2'b00, 2'b10};
    for (int i = 0; i < 7; i++)
    begin
      load(lt[i], rt[i]);
      chk8({6'h00, window_alarm_oe, critical_shutdown_oe}, {6'h00, ex[i]});
      acc(8'h94, IDX_LOCAL, lt[i], 1'b1);
      acc(8'h94, IDX_REMOTE, rt[i], 1'b1);
    end
    $display("alarms done");
  endtask
  task automatic t_polarity();
    host_u.wr(8'h94, IDX_POLARITY, 8'h02, ok);
    load(8'h20, 8'h20);
    chk8({6'h00, window_alarm_oe, critical_shutdown_oe}, 8'h03);
    load(8'h40, 8'h70);
    chk8({6'h00, window_alarm_oe, critical_shutdown_oe}, 8'h00);
    $display("polarity done");
  endtask
  task automatic t_foreign();
    host_u.wr(8'h90, IDX_LHI_WR, 8'h11, ok);
    chk8({7'h00, ok}, 8'h00);
    acc(8'h94, IDX_LHI_RD, 8'h3c, 1'b1);
    $display("foreign done");
  endtask
  task automatic t_addr_sel();
    host_u.wr(8'h94, IDX_ADDR_SEL, 8'h00, ok);
    acc(8'h90, IDX_LHI_RD, 8'h3c, 1'b1);
    acc(8'h94, IDX_LHI_RD, 8'h3c, 1'b0);
    do_reset(1'b1);
    acc(8'h90, IDX_LLO_RD, LOW_RST, 1'b1);
    acc(8'h94, IDX_LLO_RD, LOW_RST, 1'b0);
    $display("address select done");
  endtask
  // ==========================================================
  // Sequence and watchdog
  initial
  begin
    do_reset(1'b0);
    t_defaults();
    t_write();
    t_alarms();
    t_polarity();
    t_foreign();
    t_addr_sel();
    final_report();
  end
  initial
  begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    final_report();
  end
endmodule // test_tmon_top

bind tmon_top tmon_top_asserts chk_u (.mclk, .sys_rst, .serial_clock_line, .serial_data_line_out,
  .serial_data_line_oe, .window_alarm_out, .window_alarm_oe, .critical_shutdown_n, .critical_shutdown_oe,
  .conv_start, .conv_busy);
